/* File: bench/scr_host_model.sv */
// Serial host model that shifts whole or partial configuration words into the bank.
`timescale 1ns/10ps
`default_nettype none
module scr_host_model (
    // Clock and request.
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic [23:0] word_i,
    input wire logic [4:0] nbits_i,
    // Serial pins and completion.
    output logic ser_clk_o,
    output logic ser_data_o,
    output logic ser_latch_o,
    output logic done_o
);
    initial begin
        logic go_seen;
        {ser_clk_o, ser_data_o, ser_latch_o, done_o} = 4'h0;
        forever begin
            @(posedge clk_i);
            go_seen = go_i;
            #1 done_o = 1'b0;
            if (go_seen) begin
                // Select bits leave last, so each word names its own register.
                for (int i = int'(nbits_i) - 1; i >= 0; i--) begin
                    ser_data_o = word_i[i];
                    ser_clk_o = 1'b0;
                    @(posedge clk_i);
                    #1 ser_clk_o = 1'b1;
                    @(posedge clk_i);
                    #1;
                end
                // A released data line must not keep its last value.
                ser_data_o = ~ser_data_o;
                ser_clk_o = 1'b0;
                @(posedge clk_i);
                #1 ser_latch_o = 1'b1;
                @(posedge clk_i);
                #1 ser_latch_o = 1'b0;
                done_o = 1'b1;
            end
        end
    end
endmodule : scr_host_model
`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking bench for the synthesizer configuration register bank.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import scr_pkg::*;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic go = 1'b0;
    logic sel_pin = 1'b0;
    logic lock = 1'b0;
    logic [7:0] srcs = 8'h00;
    logic [23:0] word = 24'h00_0000;
    logic [4:0] nbits = 5'h18;
    logic [31:0] rnd;
    logic done, ser_clk, ser_data, ser_latch;
    logic [10:0] f_mod, f_frac;
    logic [16:0] d_rst;
    logic [9:0] cp_ua;
    logic [4:0] p_mult, mux_sel;
    logic [3:0] d_mag;
    logic [1:0] cp_sel, ref_sel;
    logic in_rng, d_en, cp_ext, p_neg, mux_pin, m_bias, m_out, lo_in, lo_drv, lo_dbl, bypass;
    logic [77:0] got;
    logic [77:0] exp_q [$];
    logic [23:0] sh [1:5] = '{SCR_RST_MODULUS, SCR_RST_FRACTION, SCR_RST_DITHER, SCR_RST_PUMP, SCR_RST_LO_PATH};
    logic [23:0] fixed [9] = '{24'h00_0000, 24'h00_0006, 24'h00_0007, 24'h70_000b, 24'h0a_67e4, 24'h00_0009,
                               24'h00_3ff9, 24'h00_0001, 24'h00_00f5};
    int err_count = 0;
    int tests_run = 0;

    assign got = {f_mod, f_frac, in_rng, d_en, d_mag, d_rst, cp_sel, cp_ua, cp_ext, p_mult, p_neg, ref_sel, mux_sel,
                  mux_pin, m_bias, m_out, lo_in, lo_drv, lo_dbl, bypass};

    scr_host_model host_u (.clk_i(clk_i), .go_i(go), .word_i(word), .nbits_i(nbits), .ser_clk_o(ser_clk),
                           .ser_data_o(ser_data), .ser_latch_o(ser_latch), .done_o(done));
    scr_top dut_u (.clk_i(clk_i), .rstn_i(rstn_i), .ser_clk_i(ser_clk), .ser_data_i(ser_data),
        .ser_latch_i(ser_latch), .lo_select_pin_i(sel_pin), .lock_detect_i(lock), .status_sources_i(srcs),
        .fractional_modulus_o(f_mod), .fractional_value_o(f_frac), .fraction_in_range_o(in_rng),
        .dither_enable_o(d_en), .dither_magnitude_o(d_mag), .dither_restart_o(d_rst),
        .charge_pump_current_sel_o(cp_sel), .charge_pump_current_ua_o(cp_ua), .external_set_resistor_o(cp_ext),
        .phase_offset_mult_o(p_mult), .phase_offset_negative_o(p_neg), .reference_scale_sel_o(ref_sel),
        .status_mux_sel_o(mux_sel), .multiplexed_status_pin_o(mux_pin), .modulator_bias_en_o(m_bias),
        .modulator_output_en_o(m_out), .lo_port_input_o(lo_in), .lo_port_drive_o(lo_drv),
        .lo_port_double_o(lo_dbl), .oscillator_bypass_o(bypass));

    ////////////////////////////////////////////////////////////////////////////
    initial forever #2 clk_i = ~clk_i;

    function automatic logic [31:0] nxt();
        rnd ^= rnd << 13;
        rnd ^= rnd >> 17;
        rnd ^= rnd << 5;
        return rnd;
    endfunction : nxt

    function automatic logic [77:0] expect_of();
        logic [4:0] ms;
        logic li;
        logic dv;
        ms = sh[4][9:5];
        li = !sel_pin && sh[5][4] && !sh[5][3];
        dv = !sh[5][4] && (sel_pin || sh[5][3]);
        return {sh[1][13:3], sh[2][13:3], sh[2][13:3] < sh[1][13:3], sh[3][20], 4'hf >> sh[3][22:21], sh[3][19:3],
                sh[4][11:10], sh[4][18] ? 10'h000 : 10'h0fa * (sh[4][11:10] + 10'h001), sh[4][18], sh[4][16:12],
                sh[4][17], sh[4][20:19], ms, ms == 5'h1f ? lock : (ms < 5'h08 ? srcs[ms[2:0]] : 1'b0),
                sh[5][6], sh[5][7], li, dv, li | (dv & sh[5][5]), li};
    endfunction : expect_of

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : close_out

    task automatic compare(input logic [77:0] e, input logic [77:0] g);
        tests_run++;
        if (g !== e) begin
            err_count++;
            $display("ERROR at %0t: got %h expected %h", $time, g, e);
        end
    endtask : compare

    // Only whole words with a known select and a nonzero modulus may move a shadow.
    task automatic put(input logic [23:0] w, input logic [4:0] n);
        int k;
        word = w;
        nbits = n;
        go = 1'b1;
        @(posedge clk_i);
        #1 go = 1'b0;
        for (k = 0; k < 200 && done !== 1'b1; k++) @(posedge clk_i);
        if (k == 200) begin
            err_count++;
            close_out();
        end
        if (n == 5'h18 && w[2:0] inside {[3'h1:3'h5]} && !(w[2:0] == 3'h1 && w[13:3] == 11'h000)) sh[w[2:0]] = w;
        exp_q.push_back(expect_of());
        repeat (5) @(posedge clk_i);
        #1;
    endtask : put

    ////////////////////////////////////////////////////////////////////////////
    initial forever begin
        @(posedge clk_i);
        if (done === 1'b1) begin
            repeat (4) @(posedge clk_i);
            #1 compare(exp_q.size() ? exp_q.pop_front() : {78{1'bx}}, got);
        end
    end

    initial begin
        logic [31:0] r;
        logic [23:0] w;
        rnd = 32'h0001_6f2e;
        repeat (6) @(posedge clk_i);
        #1 rstn_i = 1'b1;
        foreach (fixed[i]) put(fixed[i], 5'h18);
        for (int i = 0; i < 40; i++) begin
            r = nxt();
            lock = r[31];
            srcs = r[30:23];
            w = 24'(nxt());
            w[2:0] = 3'h1 + 3'(i % 5);
            if (w[2:0] == 3'h2) w[13:3] = 11'(r % sh[1][13:3]);
            if (w[2:0] == 3'h5) {sel_pin, w[5], w[4], w[3]} = {r[2:1], 1'b0, r[0]};
            put(w, (i % 7 == 3) ? 5'h0c : 5'h18);
        end
        if (exp_q.size() != 0) err_count++;
        close_out();
    end
endmodule : testbench
`default_nettype wire

/* File: common/scr_pkg.sv */
// Shared constants for the synthesizer configuration register bank.
package scr_pkg;

    //////////////////////////////////////////////////////////////////////////////
    // Serial word framing.
    localparam int SCR_WORD_W = 24;
    localparam int SCR_SEL_W = 3;
    localparam logic [4:0] SCR_WORD_BITS = 5'h18;

    // Three low bits of a word pick the target register.
    localparam logic [2:0] SCR_SEL_MODULUS = 3'h1;
    localparam logic [2:0] SCR_SEL_FRACTION = 3'h2;
    localparam logic [2:0] SCR_SEL_DITHER = 3'h3;
    localparam logic [2:0] SCR_SEL_PUMP = 3'h4;
    localparam logic [2:0] SCR_SEL_LO_PATH = 3'h5;

    //////////////////////////////////////////////////////////////////////////////
    // Field positions (low bit) and widths.
    localparam int SCR_DIV_LSB = 3;
    localparam int SCR_DIV_W = 11;
    localparam int SCR_DRST_LSB = 3;
    localparam int SCR_DRST_W = 17;
    localparam int SCR_DEN_BIT = 20;
    localparam int SCR_DMAG_LSB = 21;
    localparam int SCR_DMAG_W = 2;
    localparam int SCR_MUX_LSB = 5;
    localparam int SCR_MUX_W = 5;
    localparam int SCR_CPI_LSB = 10;
    localparam int SCR_CPI_W = 2;
    localparam int SCR_POFS_LSB = 12;
    localparam int SCR_POFS_W = 5;
    localparam int SCR_PPOL_BIT = 17;
    localparam int SCR_CPSRC_BIT = 18;
    localparam int SCR_REFS_LSB = 19;
    localparam int SCR_REFS_W = 2;
    localparam int SCR_LO_DRV_BIT = 3;
    localparam int SCR_LO_IN_BIT = 4;
    localparam int SCR_LO_DIV_BIT = 5;
    localparam int SCR_MBIAS_BIT = 6;
    localparam int SCR_MOUT_BIT = 7;

    //////////////////////////////////////////////////////////////////////////////
    // Power-up words.
    localparam logic [23:0] SCR_RST_MODULUS = 24'h00_3001;
    localparam logic [23:0] SCR_RST_FRACTION = 24'h00_1802;
    localparam logic [23:0] SCR_RST_DITHER = 24'h10_000b;
    localparam logic [23:0] SCR_RST_PUMP = 24'h0a_a7e4;
    localparam logic [23:0] SCR_RST_LO_PATH = 24'h00_00d5;

    // Dither magnitude code to magnitude; code zero is the power-up 15.
    localparam logic [3:0] SCR_DMAG_TABLE [4] = '{4'hf, 4'h7, 4'h3, 4'h1};

    // Nominal pump currents in microamps, by current code.
    localparam logic [9:0] SCR_CPI_TABLE [4] = '{10'h0fa, 10'h1f4, 10'h2ee, 10'h3e8};

    // Status mux code that routes lock detect.
    localparam logic [4:0] SCR_MUX_LOCK = 5'h1f;
    localparam int SCR_STATUS_W = 8;

endpackage : scr_pkg

/* File: common/scr_word_if.sv */
// Carrier for a completed 24-bit configuration word.
`timescale 1ns/10ps
`default_nettype none
interface scr_word_if;
    import scr_pkg::*;
    logic [SCR_WORD_W-1:0] word;
    logic valid;
    modport src (output word, output valid);
    modport dst (input word, input valid);
endinterface : scr_word_if
`default_nettype wire

/* File: src/scr_lo_port_dec.sv */
// LO port direction and ratio decode from the select pin and path bits.
`timescale 1ns/10ps
`default_nettype none
module scr_lo_port_dec (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rstn_i,
    // Pin and stored path bits.
    input wire logic lo_select_pin_i,
    input wire logic lo_divide_bit_i,
    input wire logic lo_input_bit_i,
    input wire logic lo_drive_bit_i,
    // Registered port mode.
    output logic lo_port_input_o,
    output logic lo_port_drive_o,
    output logic lo_port_double_o
);
    logic in_next, drv_next, dbl_next;

    always_comb begin
        in_next = !lo_select_pin_i && lo_input_bit_i && !lo_drive_bit_i;
        drv_next = !lo_input_bit_i && (lo_select_pin_i || lo_drive_bit_i);
        dbl_next = drv_next ? lo_divide_bit_i : in_next;
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            lo_port_input_o <= 1'b0;
            lo_port_drive_o <= 1'b0;
            lo_port_double_o <= 1'b0;
        end else begin
            lo_port_input_o <= in_next;
            lo_port_drive_o <= drv_next;
            lo_port_double_o <= dbl_next;
        end
    end

    chk_lo_port_mode: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !lo_select_pin_i && !lo_input_bit_i && !lo_drive_bit_i |=> !lo_port_drive_o && !lo_port_input_o)
        else $error("LO port not disabled with all selects low");

endmodule : scr_lo_port_dec
`default_nettype wire

/* File: src/scr_serial_rx.sv */
// Serial word receiver: shifts bits in and hands over whole words on latch.
`timescale 1ns/10ps
`default_nettype none
module scr_serial_rx
    import scr_pkg::*;
(
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rstn_i,
    // Serial pins.
    input wire logic ser_clk_i,
    input wire logic ser_data_i,
    input wire logic ser_latch_i,
    // Completed words.
    scr_word_if.src word_if
);
    logic sclk_q_reg, sclk_q_next, latch_q_reg, latch_q_next, valid_reg, valid_next;
    logic [SCR_WORD_W-1:0] shift_reg, shift_next, word_reg, word_next;
    logic [4:0] count_reg, count_next;
    logic sclk_rise, latch_rise;

    assign sclk_rise = ser_clk_i && !sclk_q_reg;
    assign latch_rise = ser_latch_i && !latch_q_reg;

    // Bits arrive most significant first; the count saturates so that extra
    // leading bits simply fall off the top.
    always_comb begin
        sclk_q_next = ser_clk_i;
        latch_q_next = ser_latch_i;
        shift_next = shift_reg;
        count_next = count_reg;
        word_next = word_reg;
        valid_next = 1'b0;
        if (sclk_rise) begin
            shift_next = {shift_reg[SCR_WORD_W-2:0], ser_data_i};
            if (count_reg != SCR_WORD_BITS) begin
                count_next = count_reg + 5'h1;
            end
        end
        if (latch_rise) begin
            if (count_reg == SCR_WORD_BITS) begin
                word_next = shift_reg;
                valid_next = 1'b1;
            end
            count_next = 5'h0;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sclk_q_reg <= 1'b0;
            latch_q_reg <= 1'b0;
            shift_reg <= '0;
            count_reg <= 5'h0;
            word_reg <= '0;
            valid_reg <= 1'b0;
        end else begin
            sclk_q_reg <= sclk_q_next;
            latch_q_reg <= latch_q_next;
            shift_reg <= shift_next;
            count_reg <= count_next;
            word_reg <= word_next;
            valid_reg <= valid_next;
        end
    end

    assign word_if.word = word_reg;
    assign word_if.valid = valid_reg;

    chk_partial_word_dropped: assert property (@(posedge clk_i) disable iff (!rstn_i)
        latch_rise && count_reg != SCR_WORD_BITS |=> !valid_reg)
        else $error("partial serial word was handed over");
    chk_full_word_taken: assert property (@(posedge clk_i) disable iff (!rstn_i)
        latch_rise && count_reg == SCR_WORD_BITS |=> valid_reg && word_reg == $past(shift_reg) ##1 !valid_reg)
        else $error("full serial word not handed over as one pulse");

endmodule : scr_serial_rx
`default_nettype wire

/* File: src/scr_top.sv */
// Configuration register bank of a fractional-N synthesizer and IQ modulator.
//
// Function
// - 010 writes fraction, 011 writes dither control.
// - 100 writes pump/reference, 101 writes LO path.
// - Eleven-bit modulus above selects, powers up 1536.
// - Dither enable powers up set.
// - Seventeen-bit dither restart value, any value.
// - Internal reference: bits 11:10 pick pump current.
// - Source bit set selects external set resistor.
// - Bits 16:12 set phase offset, 22.5 degree steps.
// - Bit 17 sets phase offset polarity.
// - Reference scaled by two, one, half, quarter.
// - Status pin selectable, lock detect by default.
// - Separate modulator bias and output enables.
// - Select low, input set, drive clear: port input.
// - Select low, input and drive clear: disabled.
// - Input clear, select or drive set: drive output; divide bit picks 1x/2x.
// - Oscillator bypass closes loop through LO port.
// - 001 writes the modulus register.
// - Oscillator equals twice detector times int+frac/mod.
`timescale 1ns/10ps
`default_nettype none
module scr_top
    import scr_pkg::*;
#(
    parameter int STATUS_W = SCR_STATUS_W
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rstn_i,
    // Serial configuration pins.
    input wire logic ser_clk_i,
    input wire logic ser_data_i,
    input wire logic ser_latch_i,
    // External LO select pin.
    input wire logic lo_select_pin_i,
    // Internal signals offered to the status pin.
    input wire logic lock_detect_i,
    input wire logic [STATUS_W-1:0] status_sources_i,
    // Divider settings.
    output logic [SCR_DIV_W-1:0] fractional_modulus_o,
    output logic [SCR_DIV_W-1:0] fractional_value_o,
    output logic fraction_in_range_o,
    // Sigma-delta dither.
    output logic dither_enable_o,
    output logic [3:0] dither_magnitude_o,
    output logic [SCR_DRST_W-1:0] dither_restart_o,
    // Charge pump, phase detector and reference path.
    output logic [SCR_CPI_W-1:0] charge_pump_current_sel_o,
    output logic [9:0] charge_pump_current_ua_o,
    output logic external_set_resistor_o,
    output logic [SCR_POFS_W-1:0] phase_offset_mult_o,
    output logic phase_offset_negative_o,
    output logic [SCR_REFS_W-1:0] reference_scale_sel_o,
    output logic [SCR_MUX_W-1:0] status_mux_sel_o,
    output logic multiplexed_status_pin_o,
    // Modulator and LO port.
    output logic modulator_bias_en_o,
    output logic modulator_output_en_o,
    output logic lo_port_input_o,
    output logic lo_port_drive_o,
    output logic lo_port_double_o,
    output logic oscillator_bypass_o
);

    //////////////////////////////////////////////////////////////////////////////
    // Serial word receiver.

    scr_word_if word_bus ();

    scr_serial_rx u_rx (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .ser_clk_i(ser_clk_i),
        .ser_data_i(ser_data_i),
        .ser_latch_i(ser_latch_i),
        .word_if(word_bus)
    );

    logic [SCR_WORD_W-1:0] wd;
    logic [SCR_SEL_W-1:0] sel;
    assign wd = word_bus.word;
    assign sel = word_bus.word[SCR_SEL_W-1:0];

    //////////////////////////////////////////////////////////////////////////////
    // Configuration fields.

    logic [SCR_DIV_W-1:0] modulus_reg, modulus_next;
    logic [SCR_DIV_W-1:0] fraction_reg, fraction_next;
    logic dither_en_reg, dither_en_next;
    logic [SCR_DMAG_W-1:0] dither_mag_reg, dither_mag_next;
    logic [SCR_DRST_W-1:0] dither_rst_reg, dither_rst_next;
    logic [SCR_CPI_W-1:0] cp_cur_reg, cp_cur_next;
    logic cp_src_reg, cp_src_next;
    logic [SCR_POFS_W-1:0] ph_ofs_reg, ph_ofs_next;
    logic ph_pol_reg, ph_pol_next;
    logic [SCR_REFS_W-1:0] ref_scale_reg, ref_scale_next;
    logic [SCR_MUX_W-1:0] mux_sel_reg, mux_sel_next;
    logic lo_div_reg, lo_div_next;
    logic lo_in_reg, lo_in_next;
    logic lo_drv_reg, lo_drv_next;
    logic mod_bias_reg, mod_bias_next;
    logic mod_out_reg, mod_out_next;

    // Only defined fields are lifted out of a word; reserved bits never reach
    // a configuration flip-flop, so whatever the host puts there has no effect.
    always_comb begin
        modulus_next = modulus_reg;
        fraction_next = fraction_reg;
        dither_en_next = dither_en_reg;
        dither_mag_next = dither_mag_reg;
        dither_rst_next = dither_rst_reg;
        cp_cur_next = cp_cur_reg;
        cp_src_next = cp_src_reg;
        ph_ofs_next = ph_ofs_reg;
        ph_pol_next = ph_pol_reg;
        ref_scale_next = ref_scale_reg;
        mux_sel_next = mux_sel_reg;
        lo_div_next = lo_div_reg;
        lo_in_next = lo_in_reg;
        lo_drv_next = lo_drv_reg;
        mod_bias_next = mod_bias_reg;
        mod_out_next = mod_out_reg;
        if (word_bus.valid) begin
            unique case (sel)
                SCR_SEL_MODULUS: begin
                    // A zero modulus is outside the legal range and is not taken.
                    if (wd[SCR_DIV_LSB +: SCR_DIV_W] != '0) begin
                        modulus_next = wd[SCR_DIV_LSB +: SCR_DIV_W];
                    end
                end
                SCR_SEL_FRACTION: begin
                    fraction_next = wd[SCR_DIV_LSB +: SCR_DIV_W];
                end
                SCR_SEL_DITHER: begin
                    dither_en_next = wd[SCR_DEN_BIT];
                    dither_mag_next = wd[SCR_DMAG_LSB +: SCR_DMAG_W];
                    dither_rst_next = wd[SCR_DRST_LSB +: SCR_DRST_W];
                end
                SCR_SEL_PUMP: begin
                    mux_sel_next = wd[SCR_MUX_LSB +: SCR_MUX_W];
                    cp_cur_next = wd[SCR_CPI_LSB +: SCR_CPI_W];
                    ph_ofs_next = wd[SCR_POFS_LSB +: SCR_POFS_W];
                    ph_pol_next = wd[SCR_PPOL_BIT];
                    cp_src_next = wd[SCR_CPSRC_BIT];
                    ref_scale_next = wd[SCR_REFS_LSB +: SCR_REFS_W];
                end
                SCR_SEL_LO_PATH: begin
                    lo_drv_next = wd[SCR_LO_DRV_BIT];
                    lo_in_next = wd[SCR_LO_IN_BIT];
                    lo_div_next = wd[SCR_LO_DIV_BIT];
                    mod_bias_next = wd[SCR_MBIAS_BIT];
                    mod_out_next = wd[SCR_MOUT_BIT];
                end
                // Integer, oscillator and external oscillator words belong
                // to other blocks and pass by untouched.
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            modulus_reg <= SCR_RST_MODULUS[SCR_DIV_LSB +: SCR_DIV_W];
            fraction_reg <= SCR_RST_FRACTION[SCR_DIV_LSB +: SCR_DIV_W];
            dither_en_reg <= SCR_RST_DITHER[SCR_DEN_BIT];
            dither_mag_reg <= SCR_RST_DITHER[SCR_DMAG_LSB +: SCR_DMAG_W];
            dither_rst_reg <= SCR_RST_DITHER[SCR_DRST_LSB +: SCR_DRST_W];
            cp_cur_reg <= SCR_RST_PUMP[SCR_CPI_LSB +: SCR_CPI_W];
            cp_src_reg <= SCR_RST_PUMP[SCR_CPSRC_BIT];
            ph_ofs_reg <= SCR_RST_PUMP[SCR_POFS_LSB +: SCR_POFS_W];
            ph_pol_reg <= SCR_RST_PUMP[SCR_PPOL_BIT];
            ref_scale_reg <= SCR_RST_PUMP[SCR_REFS_LSB +: SCR_REFS_W];
            mux_sel_reg <= SCR_RST_PUMP[SCR_MUX_LSB +: SCR_MUX_W];
            lo_div_reg <= SCR_RST_LO_PATH[SCR_LO_DIV_BIT];
            lo_in_reg <= SCR_RST_LO_PATH[SCR_LO_IN_BIT];
            lo_drv_reg <= SCR_RST_LO_PATH[SCR_LO_DRV_BIT];
            mod_bias_reg <= SCR_RST_LO_PATH[SCR_MBIAS_BIT];
            mod_out_reg <= SCR_RST_LO_PATH[SCR_MOUT_BIT];
        end else begin
            modulus_reg <= modulus_next;
            fraction_reg <= fraction_next;
            dither_en_reg <= dither_en_next;
            dither_mag_reg <= dither_mag_next;
            dither_rst_reg <= dither_rst_next;
            cp_cur_reg <= cp_cur_next;
            cp_src_reg <= cp_src_next;
            ph_ofs_reg <= ph_ofs_next;
            ph_pol_reg <= ph_pol_next;
            ref_scale_reg <= ref_scale_next;
            mux_sel_reg <= mux_sel_next;
            lo_div_reg <= lo_div_next;
            lo_in_reg <= lo_in_next;
            lo_drv_reg <= lo_drv_next;
            mod_bias_reg <= mod_bias_next;
            mod_out_reg <= mod_out_next;
        end
    end

    //////////////////////////////////////////////////////////////////////////////
    // Derived settings: status mux, pump current, dither magnitude, range flag.

    logic status_reg, status_next;
    logic [9:0] cp_ua_reg, cp_ua_next;
    logic [3:0] mag_reg, mag_next;
    logic in_range_reg, in_range_next;

    always_comb begin
        status_next = 1'b0;
        if (mux_sel_reg == SCR_MUX_LOCK) begin
            status_next = lock_detect_i;
        end else begin
            for (int i = 0; i < STATUS_W; i++) begin
                if (mux_sel_reg == SCR_MUX_W'(i)) begin
                    status_next = status_sources_i[i];
                end
            end
        end
        // With the external resistor the nominal current is trimmed off chip,
        // so the reported figure drops to zero rather than guess at it.
        cp_ua_next = cp_src_reg ? 10'h000 : SCR_CPI_TABLE[cp_cur_reg];
        mag_next = SCR_DMAG_TABLE[dither_mag_reg];
        // Drops low when a host breaks the fraction bound; the divider still runs.
        in_range_next = fraction_reg < modulus_reg;
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            status_reg <= 1'b0;
            cp_ua_reg <= 10'h000;
            mag_reg <= 4'h0;
            in_range_reg <= 1'b0;
        end else begin
            status_reg <= status_next;
            cp_ua_reg <= cp_ua_next;
            mag_reg <= mag_next;
            in_range_reg <= in_range_next;
        end
    end

    //////////////////////////////////////////////////////////////////////////////
    // LO port decode.

    scr_lo_port_dec u_lo (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .lo_select_pin_i(lo_select_pin_i),
        .lo_divide_bit_i(lo_div_reg),
        .lo_input_bit_i(lo_in_reg),
        .lo_drive_bit_i(lo_drv_reg),
        .lo_port_input_o(lo_port_input_o),
        .lo_port_drive_o(lo_port_drive_o),
        .lo_port_double_o(lo_port_double_o)
    );

    // In bypass the port takes the external oscillator while the pump keeps
    // steering it, so bypass is simply the input mode of the port.
    assign oscillator_bypass_o = lo_port_input_o;

    //////////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from flip-flops.

    assign fractional_modulus_o = modulus_reg;
    assign fractional_value_o = fraction_reg;
    assign fraction_in_range_o = in_range_reg;
    assign dither_enable_o = dither_en_reg;
    assign dither_magnitude_o = mag_reg;
    assign dither_restart_o = dither_rst_reg;
    assign charge_pump_current_sel_o = cp_cur_reg;
    assign charge_pump_current_ua_o = cp_ua_reg;
    assign external_set_resistor_o = cp_src_reg;
    assign phase_offset_mult_o = ph_ofs_reg;
    assign phase_offset_negative_o = ph_pol_reg;
    assign reference_scale_sel_o = ref_scale_reg;
    assign status_mux_sel_o = mux_sel_reg;
    assign multiplexed_status_pin_o = status_reg;
    assign modulator_bias_en_o = mod_bias_reg;
    assign modulator_output_en_o = mod_out_reg;

    //////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    sequence s_word(logic [2:0] code);
        word_bus.valid && sel == code;
    endsequence

    chk_fraction_write: assert property (
        s_word(SCR_SEL_FRACTION) |=> fractional_value_o == $past(wd[SCR_DIV_LSB +: SCR_DIV_W]))
        else $error("fraction word did not update the fraction");
    chk_dither_write: assert property (
        s_word(SCR_SEL_DITHER) |=> dither_restart_o == $past(wd[SCR_DRST_LSB +: SCR_DRST_W])
            && dither_enable_o == $past(wd[SCR_DEN_BIT]))
        else $error("dither word did not update dither settings");
    chk_pump_write: assert property (
        s_word(SCR_SEL_PUMP) |=> phase_offset_mult_o == $past(wd[SCR_POFS_LSB +: SCR_POFS_W])
            && phase_offset_negative_o == $past(wd[SCR_PPOL_BIT]) ##1
            charge_pump_current_ua_o == (external_set_resistor_o ? 10'h000 : SCR_CPI_TABLE[$past(wd[11:10], 2)]))
        else $error("pump word did not update pump settings");
    chk_lo_word_decode: assert property (
        s_word(SCR_SEL_LO_PATH) ##0 wd[SCR_LO_IN_BIT] && !wd[SCR_LO_DRV_BIT] && !lo_select_pin_i
            ##1 !lo_select_pin_i |=> lo_port_input_o && !lo_port_drive_o)
        else $error("LO port not in input mode");
    chk_modulus_hold: assert property (
        !(word_bus.valid && sel == SCR_SEL_MODULUS) || wd[SCR_DIV_LSB +: SCR_DIV_W] == '0
            |=> $stable(fractional_modulus_o))
        else $error("modulus changed without a legal modulus word");
    chk_status_lock: assert property (
        status_mux_sel_o == SCR_MUX_LOCK && $stable(status_mux_sel_o) |=> multiplexed_status_pin_o == $past(lock_detect_i))
        else $error("status pin does not follow lock detect");

    // Each write must reach its own fields; the pump source and LO drive checks follow the stored bits, the magnitude check the word.
    chk_modulus_write: assert property (
        s_word(SCR_SEL_MODULUS) ##0 wd[SCR_DIV_LSB +: SCR_DIV_W] != '0
            |=> fractional_modulus_o == $past(wd[SCR_DIV_LSB +: SCR_DIV_W]))
        else $error("modulus word did not update the modulus");

    chk_dither_magnitude: assert property (
        s_word(SCR_SEL_DITHER) |=> ##1
            dither_magnitude_o == SCR_DMAG_TABLE[$past(wd[SCR_DMAG_LSB +: SCR_DMAG_W], 2)])
        else $error("dither magnitude not decoded from its code");

    chk_reference_write: assert property (
        s_word(SCR_SEL_PUMP) |=> reference_scale_sel_o == $past(wd[SCR_REFS_LSB +: SCR_REFS_W]))
        else $error("pump word did not update reference scale");

    chk_pump_source: assert property (
        external_set_resistor_o |=> charge_pump_current_ua_o == 10'h000)
        else $error("pump current reported with external resistor selected");

    chk_lo_path_write: assert property (
        s_word(SCR_SEL_LO_PATH) |=> modulator_bias_en_o == $past(wd[SCR_MBIAS_BIT])
            && modulator_output_en_o == $past(wd[SCR_MOUT_BIT]))
        else $error("LO path word did not update modulator enables");

    chk_lo_drive_mode: assert property (
        !lo_in_reg && (lo_select_pin_i || lo_drv_reg) |=> lo_port_drive_o && !lo_port_input_o
            && lo_port_double_o == $past(lo_div_reg))
        else $error("LO port not driving with the selected ratio");

endmodule : scr_top
`default_nettype wire
